// ==== hw/sfr_irq_pkg.sv ====
package sfr_irq_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [7:0] ADDR_IRQ_ENABLE_1 = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ENABLE_2 = 8'h01;
  localparam logic [7:0] ADDR_IRQ_FLAG_1 = 8'h02;
  localparam logic [7:0] ADDR_IRQ_FLAG_2 = 8'h03;

  localparam int BIT_WATCHDOG_IRQ_EN = 0;
  localparam int BIT_OSC_FAULT_IRQ_EN = 1;
  localparam int BIT_PIN_NMI_IRQ_EN = 4;
  localparam int BIT_FLASH_ACCV_IRQ_EN = 5;

  localparam int BIT_WATCHDOG_EVENT_FLAG = 0;
  localparam int BIT_OSC_FAULT_FLAG = 1;
  localparam int BIT_POWER_ON_FLAG = 2;
  localparam int BIT_EXT_RESET_FLAG = 3;
  localparam int BIT_PIN_NMI_FLAG = 4;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic RST_ENABLE_BIT = 1'b0;
  localparam logic RST_WATCHDOG_EVENT_FLAG = 1'b0;
  localparam logic RST_OSC_FAULT_FLAG = 1'b1;
  localparam logic RST_POWER_ON_FLAG = 1'b1;
  localparam logic RST_EXT_RESET_FLAG = 1'b0;
  localparam logic RST_PIN_NMI_FLAG = 1'b0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic watchdog_expired;
    logic key_violation;
    logic osc_fault;
    logic ext_reset_pin;
    logic pin_nmi;
    logic flash_access_violation;
  } sfr_event_t;

  typedef struct packed {
    logic watchdog_irq;
    logic osc_fault_irq;
    logic pin_nmi_irq;
    logic flash_access_violation_irq;
  } sfr_irq_req_t;

endpackage : sfr_irq_pkg

// ==== hw/sfr_sticky_bit.sv ====
`timescale 1ns/1ns
// One software-accessible flag bit with separate clear domains and a hardware set.
module sfr_sticky_bit #(
  parameter logic RESET_VALUE = 1'b0,
  parameter bit CLEAR_BY_PUC = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic puc_in,
  input wire logic set_in,
  input wire logic wr_in,
  input wire logic wdata_in,
  output logic q_out
);

  // Hardware set wins over a software write or clear in the same cycle, so no event is lost.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= RESET_VALUE;
    end else if (set_in) begin
      q_out <= 1'b1;
    end else if (puc_in && CLEAR_BY_PUC) begin
      q_out <= RESET_VALUE;
    end else if (wr_in) begin
      q_out <= wdata_in;
    end
  end

endmodule : sfr_sticky_bit

// ==== hw/special_function_irq_regs.sv ====
// Notes on behaviour
// - Only documented enable and flag bits exist.
// - Clear-reset bits are read/write, reset by clear.
// - Power-on bits are read/write, survive power-up clear.
// - Enable byte 00h: bits 5,4,1,0.
// - Watchdog enable gates only interval-timer interrupts.
// - Flag byte 02h: bits 4,3,2,1,0.
// - Watchdog flag set on expiry outside interval mode, or on key violation.
// - Watchdog flag cleared by power-on and pin reset.
// - Oscillator fault flag set on fault; clears to one.
// - Power-on flag set at power-up, resets to one.
// - External reset flag set by pin reset.
// - Individual enables block fault, NMI, flash requests.
`timescale 1ns/1ns
module special_function_irq_regs (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic power_up_clear_in,
  input wire logic watchdog_interval_mode_in,
  input wire sfr_irq_pkg::sfr_event_t event_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output sfr_irq_pkg::sfr_irq_req_t irq_req_out,
  output logic watchdog_irq_en_out
);
  import sfr_irq_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Only the full byte address is compared, so no mirror of a live byte exists.
  logic wr_enable_1;
  logic wr_flag_1;
  assign wr_enable_1 = wr_en_in && (addr_in == ADDR_IRQ_ENABLE_1);
  assign wr_flag_1 = wr_en_in && (addr_in == ADDR_IRQ_FLAG_1);

  // ****************************************************************
  // Enable byte
  // ****************************************************************
  logic watchdog_irq_en;
  logic osc_fault_irq_en;
  logic pin_nmi_irq_en;
  logic flash_access_violation_irq_en;

  // Clear is tested before the write, so a clear in the same cycle beats software.
  // enable byte fields
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      watchdog_irq_en <= RST_ENABLE_BIT;
      osc_fault_irq_en <= RST_ENABLE_BIT;
      pin_nmi_irq_en <= RST_ENABLE_BIT;
      flash_access_violation_irq_en <= RST_ENABLE_BIT;
    end else if (power_up_clear_in) begin
      watchdog_irq_en <= RST_ENABLE_BIT;
      osc_fault_irq_en <= RST_ENABLE_BIT;
      pin_nmi_irq_en <= RST_ENABLE_BIT;
      flash_access_violation_irq_en <= RST_ENABLE_BIT;
    end else if (wr_enable_1) begin
      watchdog_irq_en <= wdata_in[BIT_WATCHDOG_IRQ_EN];
      osc_fault_irq_en <= wdata_in[BIT_OSC_FAULT_IRQ_EN];
      pin_nmi_irq_en <= wdata_in[BIT_PIN_NMI_IRQ_EN];
      flash_access_violation_irq_en <= wdata_in[BIT_FLASH_ACCV_IRQ_EN];
    end
  end

  // ****************************************************************
  // Flag byte
  // ****************************************************************
  // Each flag is one sticky cell; the clear domain is chosen per instance.
  logic watchdog_event_flag;
  logic osc_fault_flag;
  logic power_on_flag;
  logic ext_reset_flag;
  logic pin_nmi_flag;
  logic watchdog_reset_event;

  // watchdog flag set
  // Expiry only counts as a reset event outside interval mode.
  assign watchdog_reset_event = (event_in.watchdog_expired && !watchdog_interval_mode_in) ||
                                event_in.key_violation;

  // power-on domain bit
  // The pin reset clears it, but a same-cycle watchdog event still wins.
  // A pin reset also beats a software write that lands in the same cycle.
  sfr_sticky_bit #(
    .RESET_VALUE(RST_WATCHDOG_EVENT_FLAG),
    .CLEAR_BY_PUC(1'b0)
  ) u_watchdog_flag (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .puc_in(1'b0),
    .set_in(watchdog_reset_event),
    .wr_in(wr_flag_1 || event_in.ext_reset_pin),
    .wdata_in(!event_in.ext_reset_pin && wdata_in[BIT_WATCHDOG_EVENT_FLAG]),
    .q_out(watchdog_event_flag)
  );

  sfr_sticky_bit #(
    .RESET_VALUE(RST_OSC_FAULT_FLAG),
    .CLEAR_BY_PUC(1'b1)
  ) u_osc_fault_flag (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .puc_in(power_up_clear_in),
    .set_in(event_in.osc_fault),
    .wr_in(wr_flag_1),
    .wdata_in(wdata_in[BIT_OSC_FAULT_FLAG]),
    .q_out(osc_fault_flag)
  );

  // power-on flag
  // Power-on itself is the asynchronous reset, which loads one.
  sfr_sticky_bit #(
    .RESET_VALUE(RST_POWER_ON_FLAG),
    .CLEAR_BY_PUC(1'b0)
  ) u_power_on_flag (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .puc_in(1'b0),
    .set_in(1'b0),
    .wr_in(wr_flag_1),
    .wdata_in(wdata_in[BIT_POWER_ON_FLAG]),
    .q_out(power_on_flag)
  );

  sfr_sticky_bit #(
    .RESET_VALUE(RST_EXT_RESET_FLAG),
    .CLEAR_BY_PUC(1'b0)
  ) u_ext_reset_flag (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .puc_in(1'b0),
    .set_in(event_in.ext_reset_pin),
    .wr_in(wr_flag_1),
    .wdata_in(wdata_in[BIT_EXT_RESET_FLAG]),
    .q_out(ext_reset_flag)
  );

  sfr_sticky_bit #(
    .RESET_VALUE(RST_PIN_NMI_FLAG),
    .CLEAR_BY_PUC(1'b1)
  ) u_pin_nmi_flag (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .puc_in(power_up_clear_in),
    .set_in(event_in.pin_nmi),
    .wr_in(wr_flag_1),
    .wdata_in(wdata_in[BIT_PIN_NMI_FLAG]),
    .q_out(pin_nmi_flag)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    case (addr_in)
      ADDR_IRQ_ENABLE_1: begin
        next_rdata[BIT_WATCHDOG_IRQ_EN] = watchdog_irq_en;
        next_rdata[BIT_OSC_FAULT_IRQ_EN] = osc_fault_irq_en;
        next_rdata[BIT_PIN_NMI_IRQ_EN] = pin_nmi_irq_en;
        next_rdata[BIT_FLASH_ACCV_IRQ_EN] = flash_access_violation_irq_en;
      end
      ADDR_IRQ_FLAG_1: begin
        next_rdata[BIT_WATCHDOG_EVENT_FLAG] = watchdog_event_flag;
        next_rdata[BIT_OSC_FAULT_FLAG] = osc_fault_flag;
        next_rdata[BIT_POWER_ON_FLAG] = power_on_flag;
        next_rdata[BIT_EXT_RESET_FLAG] = ext_reset_flag;
        next_rdata[BIT_PIN_NMI_FLAG] = pin_nmi_flag;
      end
      default: begin
        next_rdata = 8'h00; // Second bytes and others have no storage.
      end
    endcase
  end

  // Read data is registered, so it appears one cycle after the strobe.
  // Between reads the last value is held, which saves toggling on the data bus.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_en_in) begin
      rdata_out <= next_rdata;
    end
  end

  // ****************************************************************
  // Interrupt requests
  // ****************************************************************
  // individual enable gating
  // watchdog interval only
  // The global enable lives in the CPU and is deliberately not used here.
  // The flash request follows the live event, since that flag sits in the flash controller.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_req_out <= '0;
      watchdog_irq_en_out <= 1'b0;
    end else begin
      irq_req_out.watchdog_irq <= watchdog_irq_en && watchdog_interval_mode_in;
      irq_req_out.osc_fault_irq <= osc_fault_irq_en && osc_fault_flag;
      irq_req_out.pin_nmi_irq <= pin_nmi_irq_en && pin_nmi_flag;
      irq_req_out.flash_access_violation_irq <= flash_access_violation_irq_en &&
                                               event_in.flash_access_violation;
      watchdog_irq_en_out <= watchdog_irq_en;
    end
  end

endmodule : special_function_irq_regs

// ==== sim/sfr_irq_checker.sv ====
`timescale 1ns/1ns
// ****
// Port checks
// ****
module sfr_irq_checker (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic power_up_clear_in,
  input wire logic watchdog_interval_mode_in,
  input wire sfr_irq_pkg::sfr_event_t event_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire sfr_irq_pkg::sfr_irq_req_t irq_req_out,
  input wire logic watchdog_irq_en_out
);
  import sfr_irq_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // A write is read back two cycles later, with no clear to spoil it.
  sequence wr_then_rd;
    wr_en_in && addr_in == 8'h00 && !power_up_clear_in ##1 !wr_en_in && !power_up_clear_in
    ##1 rd_en_in && addr_in == 8'h00 && !power_up_clear_in;
  endsequence
  sequence flash_quiet;
    !event_in.flash_access_violation [*2];
  endsequence
  unmapped_zero_a: assert property (rd_en_in && addr_in != 8'h00 && addr_in != 8'h02
    |=> rdata_out == 8'h00) else $error("Unmapped read not zero.");
  enable_mask_a: assert property (rd_en_in && addr_in == 8'h00 |=>
    (rdata_out & 8'hcc) == 8'h00) else $error("Absent enable bit high.");
  enable_rw_a: assert property (wr_then_rd |=>
    rdata_out == ($past(wdata_in, 3) & 8'h33)) else $error("Enable readback wrong.");
  // clear drops enable
  // The enable copy on the port lags the enable register by one more cycle.
  puc_enable_a: assert property (power_up_clear_in |-> ##2 !watchdog_irq_en_out)
    else $error("Enable kept through clear.");
  puc_osc_a: assert property (power_up_clear_in ##1 !wr_en_in ##1
    rd_en_in && addr_in == 8'h02 |=> rdata_out[1]) else $error("Fault flag not set.");
  wdog_gate_a: assert property (!watchdog_interval_mode_in [*2] |=>
    !irq_req_out.watchdog_irq) else $error("Watchdog request in reset mode.");
  flash_quiet_a: assert property (flash_quiet |=> !irq_req_out.flash_access_violation_irq)
    else $error("Flash request without event.");
  rdata_hold_a: assert property (!rd_en_in |=> $stable(rdata_out))
    else $error("Read data moved.");
endmodule : sfr_irq_checker

bind special_function_irq_regs sfr_irq_checker chk (.*);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import sfr_irq_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n = 1'b0;
  logic power_up_clear = 1'b0, mode = 1'b0, wr = 1'b0, rd = 1'b0, wen;
  sfr_event_t ev = '0;
  sfr_irq_req_t irq;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, en = 8'h00, fl = 8'h06;
  logic [7:0] addrs [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, 8'hff};
  int err_total = 0;
  int compares = 0;
  // ****
  // Clock and device
  // ****
  always #25 mclk_in = ~mclk_in;
  special_function_irq_regs DUT (.mclk_in(mclk_in), .rst_n_in(rst_n),
    .power_up_clear_in(power_up_clear), .watchdog_interval_mode_in(mode), .event_in(ev),
    .addr_in(addr), .wr_en_in(wr), .rd_en_in(rd), .wdata_in(wd), .rdata_out(rdata),
    .irq_req_out(irq), .watchdog_irq_en_out(wen));
  // Every compare is counted; a miss prints at once.
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus access; the model follows writes to the two live bytes.
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (w && a == 8'h00) en = d & 8'h33;
    if (w && a == 8'h02) fl = d & 8'h1f;
    if (!w) chk(rdata, a == 8'h00 ? en : a == 8'h02 ? fl : 8'h00);
  endtask : acc
  // Requests lag state by a cycle, so two edges pass before looking.
  task irq_chk;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({3'h0, wen, irq},
      {3'h0, en[0], en[0] & mode, en[1] & fl[1], en[4] & fl[4], 1'b0});
  endtask : irq_chk
  // One event pulse; the flash request shows only while its event is seen.
  task pulse(input sfr_event_t e);
    @(posedge mclk_in);
    ev <= e;
    @(posedge mclk_in);
    ev <= '0;
    #1;
    chk({7'h0, irq.flash_access_violation_irq}, {7'h0, e.flash_access_violation & en[5]});
    if (e.ext_reset_pin) fl[3:0] = {1'b1, fl[2:1], 1'b0};
    if ((e.watchdog_expired && !mode) || e.key_violation) fl[0] = 1'b1;
    if (e.osc_fault) fl[1] = 1'b1;
    if (e.pin_nmi) fl[4] = 1'b1;
  endtask : pulse
  // Power-on reset restores every bit, the power-on flag included.
  task do_rst;
    @(posedge mclk_in);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk_in);
    rst_n <= 1'b1;
    en = 8'h00;
    fl = 8'h06;
  endtask : do_rst
  // A clear keeps the power-on kept flags and forces the others.
  task do_puc;
    @(posedge mclk_in);
    power_up_clear <= 1'b1;
    @(posedge mclk_in);
    power_up_clear <= 1'b0;
    en = 8'h00;
    fl = {4'h0, fl[3:2], 1'b1, fl[0]};
  endtask : do_puc
  task end_sim;
    $display("Errors %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // Main sequence: reset values, random access, clear, events, second reset.
  initial begin
    void'($urandom(74695));
    do_rst;
    foreach (addrs[i]) acc(1'b0, addrs[i], 8'h00);
    irq_chk;
    repeat (8) begin
      @(posedge mclk_in);
      mode <= 1'($urandom);
      acc(1'b1, 8'h00, 8'($urandom));
      acc(1'b0, 8'h00, 8'h00);
      acc(1'b1, 8'h02, 8'($urandom));
      acc(1'b1, 8'h01, 8'hff);
      acc(1'b1, 8'h03, 8'hff);
      foreach (addrs[i]) acc(1'b0, addrs[i], 8'h00);
      irq_chk;
    end
    acc(1'b1, 8'h00, 8'hff);
    acc(1'b1, 8'h02, 8'h1d);
    do_puc;
    acc(1'b0, 8'h02, 8'h00);
    acc(1'b0, 8'h00, 8'h00);
    acc(1'b1, 8'h00, 8'h33);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge mclk_in);
        mode <= 1'(m);
        acc(1'b1, 8'h02, i == 2 ? 8'h01 : 8'h00);
        pulse(sfr_event_t'(6'h01 << i));
        acc(1'b0, 8'h02, 8'h00);
        irq_chk;
      end
    end
    acc(1'b1, 8'h02, 8'h00);
    do_rst;
    acc(1'b0, 8'h02, 8'h00);
    end_sim;
  end
  // A hang runs into this limit, well beyond the expected run.
  initial begin
    #2000000;
    err_total++;
    end_sim;
  end
endmodule : tb_top
